// ---- wdt_core.sv ----
/*
  Watchdog timer core: mode decode, clearing conditions, time-out counter,
  reset request, wake request, status flags and a small register port.
  Assumes a core that pulses clear_instr, sleep controller levels, and a
  reset logic that reacts to the reset request pulse.
*/
// Added by the designer: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module wdt_core #(
  parameter int RST_CYC = wdt_pkg::WDT_RST_PULSE_CYC
) (
  input  wire logic       clk,          // 50 MHz system clock
  input  wire logic       rst,          // Synchronous reset, any device reset
  input  wire logic       lfo_pin,      // Low-frequency oscillator pin
  input  wire logic [1:0] mode_cfg,     // Configuration word mode bits
  input  wire logic       sleeping,     // Device in sleep
  input  wire logic       clear_instr,  // Clear-watchdog instruction pulse
  input  wire logic       osc_fail,     // Oscillator failure detected
  input  wire logic       startup_running, // Start-up timer running
  input  wire logic       div_sel_chg,  // Internal oscillator divider change
  input  wire logic [3:0] addr,         // Register address
  input  wire logic [7:0] wdata,        // Write data
  input  wire logic       wr,           // Write strobe
  input  wire logic       rd,           // Read strobe
  output logic      [7:0] rdata,        // Read data, cycle after strobe
  output logic            reset_req,    // Reset request to reset logic
  output logic            wake_req,     // Wake pulse to sleep controller
  output logic            active        // Watchdog counting enabled
);
  wdt_tick_if tk ();

  logic                         sw_en_reg;     // Software enable
  logic [wdt_pkg::WDT_PS_W-1:0] ps_reg;        // Period select
  logic [wdt_pkg::WDT_CNT_W-1:0] cnt_reg;      // Tick counter
  logic                         sleep_d_reg;   // Previous sleep level
  logic                         dog_rst_n_reg; // Watchdog reset flag, low on event
  logic                         to_n_reg;      // Time-out flag, low on event
  logic                         pwrdn_n_reg;   // Power-down flag, low in sleep
  logic [7:0]                   rst_cnt_reg;   // Reset pulse counter
  logic                         clr;           // Any counter clear
  logic                         expire;        // Time-out this cycle
  logic [wdt_pkg::WDT_CNT_W-1:0] limit;        // Terminal count

  // Mode decode to activity
  function automatic logic mode_active(input logic [1:0] m, input logic en, input logic slp);
    case (wdt_pkg::wdt_mode_t'(m))
      wdt_pkg::WDT_MODE_ON:   mode_active = 1'b1;
      wdt_pkg::WDT_MODE_NSLP: mode_active = !slp;
      wdt_pkg::WDT_MODE_SW:   mode_active = en;
      default:                mode_active = 1'b0;
    endcase
  endfunction : mode_active

  // Tick divider
  wdt_tick_div u_wdt_tick_div (
    .clk     (clk),
    .rst     (rst),
    .lfo_pin (lfo_pin),
    .tk      (tk)
  );

  // Activity and clear conditions; divider select change is not one
  always_comb begin
    active = mode_active(mode_cfg, sw_en_reg, sleeping);
    clr    = !active
           || clear_instr
           || (sleeping != sleep_d_reg)
           || osc_fail
           || startup_running;
    limit  = wdt_pkg::WDT_CNT_W'(1) << ps_reg;
    expire = active && !clr && tk.tick && (cnt_reg >= limit - 1'b1);
  end

  // Divider phase restarts with the counter
  assign tk.clear = clr;

  // Sleep level history for entry and exit edges
  always_ff @(posedge clk) begin
    if (rst) begin
      sleep_d_reg <= 1'b0;
    end else begin
      sleep_d_reg <= sleeping;
    end
  end

  // Tick counter, resumes from zero after a sleep-entry clear
  always_ff @(posedge clk) begin
    if (rst || clr || expire) begin
      cnt_reg <= '0;
    end else if (tk.tick) begin
      cnt_reg <= cnt_reg + 1'b1;
    end
  end

  // Control register writes
  always_ff @(posedge clk) begin
    if (rst) begin
      sw_en_reg <= 1'b0;
      ps_reg    <= wdt_pkg::WDT_PS_RESET;
    end else if (wr && addr == wdt_pkg::WDT_OFS_CTRL) begin
      sw_en_reg <= wdata[wdt_pkg::WDT_CTRL_EN_BIT];
      // Out-of-range select clamps to longest
      if (wdata[wdt_pkg::WDT_CTRL_PS_LSB +: wdt_pkg::WDT_PS_W] > wdt_pkg::WDT_PS_MAX) begin
        ps_reg <= wdt_pkg::WDT_PS_MAX;
      end else begin
        ps_reg <= wdata[wdt_pkg::WDT_CTRL_PS_LSB +: wdt_pkg::WDT_PS_W];
      end
    end
  end

  // Watchdog reset flag: event wins over software set
  // A reset meeting a standing request keeps the flag, so software sees the cause
  always_ff @(posedge clk) begin
    if (rst && !reset_req) begin
      dog_rst_n_reg <= 1'b1;
    end else if (expire) begin
      dog_rst_n_reg <= 1'b0;
    end else if (wr && addr == wdt_pkg::WDT_OFS_POWER && wdata[wdt_pkg::WDT_PWR_DOGRST_BIT]) begin
      dog_rst_n_reg <= 1'b1;
    end
  end

  // Time-out and power-down status flags
  always_ff @(posedge clk) begin
    if (rst && !reset_req) begin
      to_n_reg    <= 1'b1;
      pwrdn_n_reg <= 1'b1;
    end else if (expire) begin
      to_n_reg    <= 1'b0;
      pwrdn_n_reg <= !sleeping;
    end else if (clear_instr) begin
      to_n_reg    <= 1'b1;
      pwrdn_n_reg <= 1'b1;
    end else if (sleeping && !sleep_d_reg) begin
      to_n_reg    <= 1'b1;
      pwrdn_n_reg <= 1'b0;
    end
  end

  // Wake on sleep time-out, reset on awake time-out
  // Any reset clears the request, so it never starts out unknown
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_req    <= 1'b0;
      rst_cnt_reg <= 8'h00;
    end else begin
      wake_req <= expire && sleeping;
      if (expire && !sleeping) begin
        rst_cnt_reg <= 8'(RST_CYC);
      end else if (rst_cnt_reg != 8'h00) begin
        rst_cnt_reg <= rst_cnt_reg - 8'h01;
      end
    end
  end

  assign reset_req = (rst_cnt_reg != 8'h00);

  // Read port, data one cycle after strobe
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
    end else if (rd) begin
      case (addr)
        wdt_pkg::WDT_OFS_CTRL:   rdata <= {2'h0, ps_reg, sw_en_reg};
        wdt_pkg::WDT_OFS_POWER:  rdata <= {7'h00, dog_rst_n_reg};
        wdt_pkg::WDT_OFS_STATUS: rdata <= {6'h00, pwrdn_n_reg, to_n_reg};
        wdt_pkg::WDT_OFS_COUNT:  rdata <= cnt_reg[wdt_pkg::WDT_CNT_W-1 -: 8];
        default:                 rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end
endmodule : wdt_core

// ---- wdt_core_bench.sv ----
/* Bench for the watchdog core.
   Assumes the far model supplies oscillator and clears. */
`timescale 1ns/1ps
module wdt_core_bench;
  logic clk = 1'b0, rst = 1'b1, sleeping = 1'b0, osc_fail = 1'b0, startup_running = 1'b0, div_sel_chg = 1'b0;
  logic wr = 1'b0, rd = 1'b0, rd_q = 1'b0, rq_d = 1'b0, kick_en = 1'b0;
  logic lfo_pin, clear_instr, reset_req, wake_req, active;
  logic [1:0] mode_cfg = 2'h0;
  logic [3:0] addr = 4'h0;
  logic [7:0] wdata = 8'h00;
  logic [7:0] rdata;
  logic [7:0] exp_q[$];  // Expected read data
  logic [31:0] seed = 32'h9D6D;
  int error_cnt = 0, checks = 0, cyc = 0, n_rst = 0, n_wake = 0, n = 0;
  always #10 clk = ~clk;
  wdt_core u_wdt_core (.clk(clk), .rst(rst), .lfo_pin(lfo_pin), .mode_cfg(mode_cfg), .sleeping(sleeping),
    .clear_instr(clear_instr), .osc_fail(osc_fail), .startup_running(startup_running), .div_sel_chg(div_sel_chg),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .reset_req(reset_req),
    .wake_req(wake_req), .active(active));
  wdt_far_model u_wdt_far_model (.clk(clk), .kick_en(kick_en), .lfo_pin(lfo_pin), .clear_instr(clear_instr));
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction : xs
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask : check
  task automatic wreg(input logic [3:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask : wreg
  task automatic rreg(input logic [3:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
  endtask : rreg
  // Run until a time-out event or the limit
  task automatic span(input int lim);
    n_rst = 0;
    n_wake = 0;
    for (n = 0; n < lim && !(reset_req || wake_req); n++)
      @(posedge clk);
    repeat (8) @(posedge clk);
  endtask : span
  task automatic results;
    $display("checks %0d mismatches %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : results
  // Random divider changes, read compare, event count
  always @(posedge clk) begin
    seed <= xs(seed);
    div_sel_chg <= seed[0];
    rd_q <= rd;
    rq_d <= reset_req;
    cyc <= cyc + 1;
    if (rd_q)
      check(rdata, exp_q.pop_front());
    if (reset_req && !rq_d)
      n_rst++;
    if (wake_req)
      n_wake++;
    if (cyc == 30000) begin
      error_cnt++;
      results();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rreg(4'h0, 8'h16);
    rreg(4'h1, 8'h01);
    rreg(4'h2, 8'h03);
    rreg(4'hF, 8'h00);
    rreg(4'h3, 8'h00);
    wreg(4'h0, 8'h3E);
    rreg(4'h0, 8'h24);
    wreg(4'h0, 8'h02);
    span(1500);
    check(8'(n_rst), 8'h00);
    mode_cfg <= 2'h1;
    span(1500);
    check(8'(n_rst), 8'h00);
    wreg(4'h0, 8'h03);
    check(8'(active), 8'h01);
    kick_en <= 1'b1;
    span(1500);
    check(8'(n_rst), 8'h00);
    kick_en <= 1'b0;
    span(1500);
    check(8'(n_rst), 8'h01);
    check(8'(n > 300 && n < 600), 8'h01);
    rreg(4'h1, 8'h00);
    rreg(4'h2, 8'h02);
    wreg(4'h1, 8'h01);
    rreg(4'h1, 8'h01);
    $display("test awake done");
    mode_cfg <= 2'h3;
    repeat (350) @(posedge clk);
    sleeping <= 1'b1;
    span(1500);
    check(8'(n > 400), 8'h01);
    check(8'(n_wake), 8'h01);
    check(8'(n_rst), 8'h00);
    rreg(4'h2, 8'h00);
    mode_cfg <= 2'h2;
    span(1500);
    check(8'(n_wake), 8'h00);
    sleeping <= 1'b0;
    span(1500);
    check(8'(n_rst), 8'h01);
    $display("test sleep done");
    mode_cfg <= 2'h3;
    startup_running <= 1'b1;
    span(1500);
    check(8'(n_rst), 8'h00);
    startup_running <= 1'b0;
    osc_fail <= 1'b1;
    span(1500);
    check(8'(n_rst), 8'h00);
    $display("test holds done");
    // Reset arriving while the request stands keeps the cause flags
    osc_fail <= 1'b0;
    for (n = 0; n < 1500 && !reset_req; n++)
      @(posedge clk);
    rst <= 1'b1;
    @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rreg(4'h1, 8'h00);
    rreg(4'h2, 8'h02);
    rreg(4'h0, 8'h16);
    repeat (2) @(posedge clk);
    $display("test reset done");
    results();
  end
endmodule : wdt_core_bench

// ---- wdt_core_sva.sv ----
/* Port checker for the watchdog core.
   Assumes one clock and a synchronous reset. */
`timescale 1ns/1ps
module wdt_core_sva #(
  parameter int RST_CYC = 5
) (
  input wire logic       clk,
  input wire logic       rst,
  input wire logic [1:0] mode_cfg,
  input wire logic       sleeping,
  input wire logic       osc_fail,
  input wire logic       startup_running,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr,
  input wire logic       reset_req,
  input wire logic       wake_req,
  input wire logic       active
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (rst);
  logic [7:0] hi_reg;  // Cycles the reset request stood
  always_ff @(posedge clk) begin
    hi_reg <= reset_req ? hi_reg + 8'h01 : 8'h00;
  end
  a_off_idle: assert property (mode_cfg == 2'h0 |-> !active)
    else $error("active while off");
  a_always_on: assert property (mode_cfg == 2'h3 |-> active)
    else $error("idle in always-on mode");
  a_awake_only: assert property (mode_cfg == 2'h2 |-> active == !sleeping)
    else $error("wrong state in awake-only mode");
  a_sw_follow: assert property (wr && addr == 4'h0 && mode_cfg == 2'h1 |=> active == $past(wdata[0]))
    else $error("enable bit not followed");
  a_rst_width: assert property ($fell(reset_req) && !$past(rst) |-> hi_reg == RST_CYC)
    else $error("reset request width");
  a_no_rst_asleep: assert property ($rose(reset_req) |-> !$past(sleeping))
    else $error("reset request during sleep");
  a_startup_hold: assert property ($past(startup_running, 2) && $past(startup_running) |-> !$rose(reset_req | wake_req))
    else $error("time-out under start-up hold");
  a_wake_pulse: assert property (wake_req |=> !wake_req)
    else $error("wake request longer than one cycle");
  a_fail_hold: assert property ($past(osc_fail, 2) && $past(osc_fail) |-> !$rose(reset_req | wake_req))
    else $error("time-out under oscillator fail");
endmodule : wdt_core_sva
bind wdt_core wdt_core_sva #(.RST_CYC(RST_CYC)) u_wdt_core_sva (.clk(clk), .rst(rst), .mode_cfg(mode_cfg),
  .sleeping(sleeping), .osc_fail(osc_fail), .startup_running(startup_running), .addr(addr), .wdata(wdata), .wr(wr),
  .reset_req(reset_req), .wake_req(wake_req), .active(active));

// ---- wdt_far_model.sv ----
/* Far side: slow oscillator and a core issuing clears.
   Assumes the bench gates the clears with kick_en. */
`timescale 1ns/1ps
module wdt_far_model (
  input  wire logic clk,
  input  wire logic kick_en,
  output logic      lfo_pin,
  output logic      clear_instr = 1'b0
);
  logic [2:0] ph_reg = 3'h0;  // Oscillator phase, shortened period
  logic [7:0] kk_reg = 8'h00; // Clear interval
  // Free-running oscillator
  always_ff @(posedge clk) begin
    ph_reg <= ph_reg + 3'h1;
  end
  assign lfo_pin = ph_reg[2];
  // Clear well inside each period
  always_ff @(posedge clk) begin
    kk_reg      <= (kk_reg == 8'h95) ? 8'h00 : kk_reg + 8'h01;
    clear_instr <= kick_en && kk_reg == 8'h00;
  end
endmodule : wdt_far_model

// ---- wdt_pkg.sv ----
/*
  Constants, types and register map of the watchdog timer block.
  Assumes a 50 MHz system clock and a low-frequency oscillator input on a pin.
*/
// Contract
// - Count 1 ms ticks from low-frequency oscillator
// - Mode 11 runs always, even asleep
// - Mode 10 runs awake, stops asleep
// - Mode 01 follows software enable bit
// - Disabled watchdog holds counter cleared
// - Period select 1 ms to 256 s, reset 2 s
// - Reset and clear instruction clear counter
// - Sleep entry and exit clear counter
// - Enabled in sleep resumes from zero
// - Oscillator failure clears counter
// - Startup timer running holds counter clear
// - Divider select change leaves counter alone
// - Sleep timeout wakes, updates status flags
// - Timeout recorded in watchdog reset flag
package wdt_pkg;
  // Watchdog modes from configuration word
  typedef enum logic [1:0] {
    WDT_MODE_OFF  = 2'h0,
    WDT_MODE_SW   = 2'h1,
    WDT_MODE_NSLP = 2'h2,
    WDT_MODE_ON   = 2'h3
  } wdt_mode_t;

  // Register offsets
  localparam logic [3:0] WDT_OFS_CTRL   = 4'h0;  // Control register
  localparam logic [3:0] WDT_OFS_POWER  = 4'h1;  // Power control register
  localparam logic [3:0] WDT_OFS_STATUS = 4'h2;  // Status flags register
  localparam logic [3:0] WDT_OFS_COUNT  = 4'h3;  // Tick counter, read only

  // Control register fields
  localparam int         WDT_CTRL_EN_BIT  = 0;   // Software enable
  localparam int         WDT_CTRL_PS_LSB  = 1;   // Period select low bit
  localparam int         WDT_PS_W         = 5;   // Period select width
  localparam logic [4:0] WDT_PS_RESET     = 5'h0B; // 2048 ms, nominal 2 s
  localparam logic [4:0] WDT_PS_MAX       = 5'h12; // 2^18 ms, nominal 256 s

  // Power/status fields
  localparam int WDT_PWR_DOGRST_BIT = 0;         // Watchdog reset flag, active low
  localparam int WDT_ST_TO_BIT      = 0;         // Time-out flag, active low
  localparam int WDT_ST_PWRDN_BIT   = 1;         // Power-down flag, active low

  // Counter width for up to 2^18 ticks
  localparam int WDT_CNT_W = 19;

  // Timing
  localparam int WDT_CLK_HZ  = 50_000_000;       // System clock rate
  localparam int WDT_TICK_US = 1000;             // Nominal base interval
  localparam int WDT_LFO_DIV = 31;               // Oscillator edges per 1 ms tick
  localparam int WDT_RST_PULSE_NS = 100;         // Reset request width
  localparam int WDT_RST_PULSE_CYC =
    (WDT_RST_PULSE_NS * (WDT_CLK_HZ / 1_000_000) + 999) / 1000;
endpackage : wdt_pkg

// ---- wdt_tick_div.sv ----
/*
  Tick divider: synchronises the low-frequency oscillator and counts its
  rising edges into a 1 ms enable pulse. Assumes the oscillator is slow
  against the system clock.
*/
`timescale 1ns/1ps
module wdt_tick_div #(
  parameter int DIV = wdt_pkg::WDT_LFO_DIV
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic lfo_pin,
  wdt_tick_if.src   tk
);
  logic       sync1_reg;   // First synchroniser stage
  logic       sync2_reg;   // Second synchroniser stage
  logic       prev_reg;    // Previous synced level
  logic [5:0] div_reg;     // Edge count within tick

  // Two-flop synchroniser, edge history
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_reg <= 1'b0;
      sync2_reg <= 1'b0;
      prev_reg  <= 1'b0;
    end else begin
      sync1_reg <= lfo_pin;
      sync2_reg <= sync1_reg;
      prev_reg  <= sync2_reg;
    end
  end

  // Edge counter producing a tick every DIV edges
  always_ff @(posedge clk) begin
    if (rst || tk.clear) begin
      div_reg <= 6'h00;
      tk.tick <= 1'b0;
    end else if (sync2_reg && !prev_reg) begin
      if (div_reg == 6'(DIV - 1)) begin
        div_reg <= 6'h00;
        tk.tick <= 1'b1;
      end else begin
        div_reg <= div_reg + 6'h01;
        tk.tick <= 1'b0;
      end
    end else begin
      tk.tick <= 1'b0;
    end
  end
endmodule : wdt_tick_div

// ---- wdt_tick_if.sv ----
/*
  Interface carrying the tick from the divider to the watchdog core.
  Assumes both ends share the system clock.
*/
`timescale 1ns/1ps
interface wdt_tick_if;
  logic tick;   // One-cycle 1 ms pulse
  logic clear;  // Restart the divider phase
  modport src (output tick, input clear);
  modport dst (input tick, output clear);
endinterface : wdt_tick_if
